// File: ptu_defines.vh
// Register offsets, field positions and reset values of the periodic timer
`ifndef PTU_DEFINES_VH
`define PTU_DEFINES_VH
`define PTU_OFF_CTRL 12'h000
`define PTU_OFF_CMPA 12'h004
`define PTU_OFF_CMPP 12'h008
`define PTU_OFF_CNT 12'h00C
`define PTU_OFF_FLAG 12'h010
`define PTU_CTRL_RUN 0
`define PTU_CTRL_MODE_LO 1
`define PTU_CTRL_MODE_HI 2
`define PTU_CTRL_OC_LO 3
`define PTU_CTRL_OC_HI 4
`define PTU_CTRL_CCLR 5
`define PTU_CTRL_INIT 6
`define PTU_CTRL_POL 7
`define PTU_CTRL_CAPTS 8
`define PTU_CTRL_CKSEL_LO 9
`define PTU_CTRL_CKSEL_HI 10
`define PTU_FLAG_A 0
`define PTU_FLAG_P 1
`define PTU_CTRL_RST 11'h000
`define PTU_MODE_CMP 2'h0
`define PTU_MODE_CAP 2'h1
`define PTU_MODE_PWM 2'h2
`define PTU_MODE_TMR 2'h3
`define PTU_CNT_MAX 10'h3FF
`define PTU_RESP_OKAY 2'h0
`define PTU_RESP_SLVERR 2'h2
`endif

// File: ptu_sync_edge.v
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module ptu_sync_edge (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire pin_in, // Asynchronous pin level
	output wire level, // Synchronised level
	output wire rise, // One-cycle pulse on rising edge
	output wire fall // One-cycle pulse on falling edge
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// First stage feeds only the second stage
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else
		begin
			meta_q <= pin_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// Edges taken from synchronised stages only
	assign level = sync_q;
	assign rise = sync_q & ~prev_q;
	assign fall = ~sync_q & prev_q;
endmodule

// File: ptu_prescaler.v
// Counter clock tick generator: divides the system clock by 1, 4, 16 or 64
`timescale 1ns/1ps
module ptu_prescaler (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire [1:0] sel, // Divider select
	output wire tick // One-cycle pulse per counter clock
);
	reg [5:0] div_q;

	// Free-running divider; ticks are phase-shared by all selections
	always @(posedge aclk)
	begin
		if (!aresetn)
			div_q <= 6'h00;
		else
			div_q <= div_q + 6'h01;
	end

	assign tick = (sel == 2'h0) ? 1'b1 :
		(sel == 2'h1) ? (div_q[1:0] == 2'h3) :
		(sel == 2'h2) ? (div_q[3:0] == 4'hF) :
		(div_q == 6'h3F);
endmodule

// File: ptu_timer.v
// Periodic timer unit: PWM, single pulse and capture with AXI4-Lite registers
`timescale 1ns/1ps
`include "ptu_defines.vh"

module ptu_timer (
	input wire aclk, // System clock, 100 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire [11:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [11:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire clock_trigger_pin, // Trigger / capture pin
	input wire capture_input_pin, // Dedicated capture pin
	output reg timer_out, // Timer output pin level
	output reg timer_out_en_n, // Output enable, low while driving
	output reg irq_a, // Comparator A / capture request pulse
	output reg irq_p // Comparator P request pulse
);
	reg [10:0] ctrl_q;
	reg [9:0] compare_a_value_q;
	reg [9:0] compare_p_value_q;
	reg [9:0] cnt_q;
	reg [1:0] flag_q;
	reg run_prev_q;
	reg pwm_lvl_q;
	reg aw_got_q;
	reg w_got_q;
	reg [11:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire tick;
	wire ck_lvl;
	wire ck_rise;
	wire ck_fall;
	wire ci_lvl;
	wire ci_rise;
	wire ci_fall;
	wire run_bit;
	wire [1:0] mode;
	wire [1:0] oc;
	wire run_rise;
	wire cap_rise;
	wire cap_fall;
	wire cap_hit;
	wire a_match;
	wire p_match;
	wire wr_go;
	wire wr_ctrl;
	wire wr_flag;
	wire [10:0] wr_run_mask;
	reg [9:0] cnt_d;
	reg run_d;
	reg out_d;
	reg oe_n_d;
	reg [31:0] rd_d;
	reg rd_ok;

	assign run_bit = ctrl_q[`PTU_CTRL_RUN];
	assign mode = {ctrl_q[`PTU_CTRL_MODE_HI], ctrl_q[`PTU_CTRL_MODE_LO]};
	assign oc = {ctrl_q[`PTU_CTRL_OC_HI], ctrl_q[`PTU_CTRL_OC_LO]};
	assign run_rise = run_bit & ~run_prev_q;

	ptu_prescaler u_pre (
		.aclk(aclk),
		.aresetn(aresetn),
		.sel(ctrl_q[`PTU_CTRL_CKSEL_HI:`PTU_CTRL_CKSEL_LO]),
		.tick(tick)
	);

	// Pin is sampled at its pad, so driven transitions are seen too
	ptu_sync_edge u_ck (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(clock_trigger_pin),
		.level(ck_lvl),
		.rise(ck_rise),
		.fall(ck_fall)
	);

	ptu_sync_edge u_ci (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(capture_input_pin),
		.level(ci_lvl),
		.rise(ci_rise),
		.fall(ci_fall)
	);

	// Capture source: 0 dedicated pin, 1 trigger pin
	assign cap_rise = ctrl_q[`PTU_CTRL_CAPTS] ? ck_rise : ci_rise;
	assign cap_fall = ctrl_q[`PTU_CTRL_CAPTS] ? ck_fall : ci_fall;

	// Edge select 00 rise, 01 fall, 10 both, 11 none
	assign cap_hit = (mode == `PTU_MODE_CAP) && run_bit &&
		(((oc == 2'h0) && cap_rise) || ((oc == 2'h1) && cap_fall) ||
		((oc == 2'h2) && (cap_rise || cap_fall)));

	// Match on the tick reaching the value; never in the restart cycle,
	// where the counter still holds its stale value from the last run
	assign a_match = run_bit && run_prev_q && tick &&
		(cnt_q + 10'h001 == compare_a_value_q);
	// P of zero matches at rollover, giving 1024 counts
	assign p_match = run_bit && run_prev_q && tick &&
		(cnt_q + 10'h001 == compare_p_value_q);

	// Counter and run bit next values
	always @*
	begin
		cnt_d = cnt_q;
		run_d = run_bit;
		if (run_rise)
			cnt_d = 10'h000; // Restart from zero on run rise
		else if (run_bit && tick)
		begin
			cnt_d = cnt_q + 10'h001;
			case (mode)
			`PTU_MODE_PWM:
				if (p_match && oc != 2'h3)
					cnt_d = 10'h000; // Clear source select ignored
			`PTU_MODE_CAP:
				if (p_match)
					cnt_d = 10'h000;
			default: cnt_d = cnt_q + 10'h001;
			endcase
		end
		// Single pulse: trigger edge sets run, A match clears it
		if (mode == `PTU_MODE_PWM && oc == 2'h3)
		begin
			if (a_match)
				run_d = 1'b0;
			else if (ck_rise && !run_bit)
				run_d = 1'b1;
		end
	end

	// PWM level: high below A, 100% when A reaches period
	always @*
	begin
		out_d = timer_out;
		oe_n_d = 1'b1;
		if (mode == `PTU_MODE_PWM)
		begin
			oe_n_d = 1'b0;
			if (oc == 2'h3)
				out_d = run_bit ^ ctrl_q[`PTU_CTRL_POL];
			else if (oc == 2'h2)
				// Waveform to pin; init level then polarity invert
				out_d = pwm_lvl_q ^ ~ctrl_q[`PTU_CTRL_INIT] ^
					ctrl_q[`PTU_CTRL_POL];
			else
				// Forced level; counter still runs underneath
				out_d = oc[0];
		end
		else
			out_d = 1'b0; // No output function in capture
	end

	// Internal PWM comparator level, running in every output setting
	always @(posedge aclk)
	begin
		if (!aresetn)
			pwm_lvl_q <= 1'b0;
		else if (!run_bit)
			pwm_lvl_q <= 1'b0;
		else if ((compare_p_value_q == 10'h000) ?
			1'b0 : (compare_a_value_q >= compare_p_value_q))
			pwm_lvl_q <= 1'b1;
		else
			pwm_lvl_q <= (cnt_d < compare_a_value_q);
	end

	assign wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
	assign wr_ctrl = wr_go && (awaddr_q == `PTU_OFF_CTRL);
	assign wr_flag = wr_go && (awaddr_q == `PTU_OFF_FLAG);
	assign wr_run_mask = {10'h000, 1'b1};

	// Write channels taken in either order, then one response
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PTU_RESP_OKAY;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == `PTU_OFF_CTRL ||
					awaddr_q == `PTU_OFF_CMPA ||
					awaddr_q == `PTU_OFF_CMPP ||
					awaddr_q == `PTU_OFF_FLAG) ? `PTU_RESP_OKAY :
					`PTU_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	// Control, compare and flag registers; a hardware flag set wins over clear
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q <= `PTU_CTRL_RST;
			compare_a_value_q <= 10'h000;
			compare_p_value_q <= 10'h000;
			flag_q <= 2'h0;
			cnt_q <= 10'h000;
			run_prev_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			run_prev_q <= run_bit;
			if (wr_ctrl && wstrb_q[0])
				ctrl_q[7:0] <= wdata_q[7:0];
			else
				ctrl_q[`PTU_CTRL_RUN] <= run_d;
			if (wr_ctrl && wstrb_q[1])
				ctrl_q[10:8] <= wdata_q[10:8];
			if (wr_ctrl && wstrb_q[0] && wr_run_mask[0] && a_match &&
				mode == `PTU_MODE_PWM && oc == 2'h3)
				ctrl_q[`PTU_CTRL_RUN] <= 1'b0; // A match still ends pulse
			if (cap_hit)
				compare_a_value_q <= cnt_q; // Latch counter
			else if (wr_go && awaddr_q == `PTU_OFF_CMPA)
			begin
				if (wstrb_q[0])
					compare_a_value_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					compare_a_value_q[9:8] <= wdata_q[9:8];
			end
			if (wr_go && awaddr_q == `PTU_OFF_CMPP)
			begin
				if (wstrb_q[0])
					compare_p_value_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1])
					compare_p_value_q[9:8] <= wdata_q[9:8];
			end
			// Write one to clear; a new event in the same cycle stays set
			flag_q[`PTU_FLAG_A] <= (flag_q[`PTU_FLAG_A] &
				~(wr_flag & wstrb_q[0] & wdata_q[`PTU_FLAG_A])) |
				(a_match & mode != `PTU_MODE_CAP) | cap_hit;
			flag_q[`PTU_FLAG_P] <= (flag_q[`PTU_FLAG_P] &
				~(wr_flag & wstrb_q[0] & wdata_q[`PTU_FLAG_P])) |
				(p_match & mode != `PTU_MODE_PWM | p_match &
				oc != 2'h3);
		end
	end

	// Read decode
	always @*
	begin
		rd_d = 32'h00000000;
		rd_ok = 1'b1;
		case ({s_axi_araddr[11:2], 2'h0})
		`PTU_OFF_CTRL: rd_d = {21'h000000, ctrl_q};
		`PTU_OFF_CMPA: rd_d = {22'h000000, compare_a_value_q};
		`PTU_OFF_CMPP: rd_d = {22'h000000, compare_p_value_q};
		`PTU_OFF_CNT: rd_d = {22'h000000, cnt_q};
		`PTU_OFF_FLAG: rd_d = {30'h00000000, flag_q};
		default: rd_ok = 1'b0;
		endcase
	end

	// Read channel: address taken, data one cycle later
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PTU_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_d;
				s_axi_rresp <= rd_ok ? `PTU_RESP_OKAY : `PTU_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Pin and request outputs registered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			timer_out <= 1'b0;
			timer_out_en_n <= 1'b1;
			irq_a <= 1'b0;
			irq_p <= 1'b0;
		end
		else
		begin
			timer_out <= out_d;
			timer_out_en_n <= oe_n_d;
			irq_a <= (a_match & mode != `PTU_MODE_CAP) | cap_hit;
			irq_p <= p_match & !(mode == `PTU_MODE_PWM && oc == 2'h3);
		end
	end
endmodule

// File: ptu_timer_props.sv
// Port-level assertions for the periodic timer unit
`timescale 1ns/1ps
module ptu_timer_props (
	input wire aclk, // System clock
	input wire aresetn, // Synchronous reset, active low
	input wire s_axi_awready, // Write address ready
	input wire s_axi_wready, // Write data ready
	input wire s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire s_axi_arready, // Read address ready
	input wire [31:0] s_axi_rdata, // Read data
	input wire [1:0] s_axi_rresp, // Read response
	input wire s_axi_rvalid, // Read data valid
	input wire s_axi_rready, // Read data ready
	input wire timer_out, // Output pin level
	input wire timer_out_en_n, // Output enable, low while driving
	input wire irq_a, // A match or capture pulse
	input wire irq_p // P match pulse
);
	// One clock domain; reset silences all but the reset check
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_one_write: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken before response done");
	a_bad_read_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
		|-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
	a_irq_a_pulse: assert property (irq_a |=> !irq_a)
		else $error("A request longer than one cycle");
	a_irq_p_pulse: assert property (irq_p |=> !irq_p)
		else $error("P request longer than one cycle");
	a_idle_pin_low: assert property (timer_out_en_n && $past(timer_out_en_n)
		|-> !timer_out)
		else $error("pin level set while not driving");
	// Checked during reset itself, so no disable here
	a_reset_quiet: assert property (disable iff (1'b0) !aresetn
		|=> !s_axi_bvalid && !s_axi_rvalid && !irq_a && !irq_p && timer_out_en_n)
		else $error("outputs active after reset");
endmodule
bind ptu_timer ptu_timer_props u_props (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .timer_out(timer_out),
	.timer_out_en_n(timer_out_en_n), .irq_a(irq_a), .irq_p(irq_p));

// File: ptu_pin_model.sv
// Far-side driver for the trigger and capture pins
`timescale 1ns/1ps
module ptu_pin_model (
	input wire aclk, // System clock
	output reg trig_pin, // Trigger / capture pin level
	output reg cap_pin // Dedicated capture pin level
);
	initial
	begin
		trig_pin = 1'b0;
		cap_pin = 1'b0;
	end
	// One high pulse on the chosen pin, giving one rise and one fall
	task pulse(input bit sel, input int len);
		begin
			@(posedge aclk);
			{trig_pin, cap_pin} <= {sel, !sel};
			repeat (len) @(posedge aclk);
			{trig_pin, cap_pin} <= 2'b00;
		end
	endtask
endmodule

// File: ptu_timer_tb.sv
// Self-checking bench for the periodic timer unit
`timescale 1ns/1ps
`include "ptu_defines.vh"
module ptu_timer_tb;
	reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	reg [11:0] awaddr, araddr;
	reg [31:0] wdata;
	wire awready, wready, bvalid, arready, rvalid, trig, cap;
	wire tout, toen_n, irq_a, irq_p;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	logic [33:0] exp_q[$];
	int mismatches, n_checks, p, a, k, hi, na, np;
	int cap_exp[4] = '{1, 1, 2, 0};
	ptu_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .clock_trigger_pin(trig),
		.capture_input_pin(cap), .timer_out(tout), .timer_out_en_n(toen_n),
		.irq_a(irq_a), .irq_p(irq_p));
	ptu_pin_model m (.aclk(aclk), .trig_pin(trig), .cap_pin(cap));
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task chk(input string what, input logic [33:0] seen, input logic [33:0] e);
		begin
			n_checks++;
			if (seen !== e)
			begin
				mismatches++;
				$display("[FAIL] %s expected %0h seen %0h", what, e, seen);
			end
		end
	endtask
	task print_verdict;
		begin
			$display("Checks %0d, mismatches %0d", n_checks, mismatches);
			if (mismatches == 0 && n_checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// Write: late bready makes the response wait one cycle
	task wr(input [11:0] ad, input [31:0] d, input [1:0] er);
		bit aw, w;
		begin
			aw = 0;
			w = 0;
			awaddr <= ad;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			while (!(aw && w))
			begin
				@(posedge aclk);
				aw = aw | awready;
				w = w | wready;
				awvalid <= !aw;
				wvalid <= !w;
			end
			while (!bvalid) @(posedge aclk);
			bready <= 1'b1;
			@(posedge aclk);
			chk("bresp", bresp, er);
			bready <= 1'b0;
		end
	endtask
	// Read: expected word goes to the queue for the monitor
	task rd(input [11:0] ad, input [33:0] e);
		begin
			exp_q.push_back(e);
			araddr <= ad;
			arvalid <= 1'b1;
			do @(posedge aclk); while (!arready);
			arvalid <= 1'b0;
			while (!rvalid) @(posedge aclk);
			rready <= 1'b1;
			@(posedge aclk);
			rready <= 1'b0;
		end
	endtask
	// Count high cycles and request pulses over a window
	task watch(input int n);
		begin
			hi = 0;
			na = 0;
			np = 0;
			repeat (n)
			begin
				@(posedge aclk);
				hi += tout;
				na += irq_a;
				np += irq_p;
			end
		end
	endtask
	// Monitor takes the oldest note whenever a read completes
	always @(posedge aclk)
		if (rvalid && rready && exp_q.size() > 0)
			chk("read", {rresp, rdata}, exp_q.pop_front());
	initial
	begin
		repeat (50000) @(posedge aclk);
		mismatches++;
		print_verdict;
	end
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h00000000;
		void'($urandom(64));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 5; k++)
			rd(12'(k * 4), 34'h0);
		rd(12'h020, {2'h2, 32'h0});
		wr(12'h020, 32'h1, 2'h2);
		wr(`PTU_OFF_CMPP, 32'hFFFFFFFF, 2'h0);
		rd(`PTU_OFF_CMPP, 34'h3FF);
		p = 8 + $urandom % 40;
		a = 4 + $urandom % (p - 4);
		wr(`PTU_OFF_CMPP, p, 2'h0);
		wr(`PTU_OFF_CMPA, a, 2'h0);
		// Level and polarity bits, clear-select set throughout
		for (k = 0; k < 4; k++)
		begin
			wr(`PTU_OFF_CTRL, 32'h35 + k * 64, 2'h0);
			watch(4 * p);
			chk("pwm high", hi, 4 * ((k == 1 || k == 2) ? a : p - a));
			chk("pwm period", np, 4);
			chk("pwm enable", toen_n, 0);
		end
		// Forced levels; the counter keeps running behind them
		wr(`PTU_OFF_CTRL, 32'h25, 2'h0);
		watch(4 * p);
		chk("force low", hi, 0);
		chk("force low run", np, 4);
		wr(`PTU_OFF_CTRL, 32'h2D, 2'h0);
		watch(4 * p);
		chk("force high", hi, 4 * p);
		chk("force high run", na, 4);
		wr(`PTU_OFF_CMPA, p, 2'h0);
		wr(`PTU_OFF_CTRL, 32'h75, 2'h0);
		watch(4 * p);
		chk("full duty", hi, 4 * p);
		wr(`PTU_OFF_CMPA, a, 2'h0);
		wr(`PTU_OFF_CMPP, 32'h0, 2'h0);
		watch(1024);
		chk("zero period high", hi, a);
		chk("zero period", np, 1);
		// Single pulse: a small P with clear-select must not cut it
		wr(`PTU_OFF_CTRL, 32'h0, 2'h0);
		wr(`PTU_OFF_CMPP, 32'h3, 2'h0);
		wr(`PTU_OFF_CTRL, 32'h7C, 2'h0);
		// Width is the run rise cycle plus counts 0 to A-1
		fork
			m.pulse(1'b1, 2);
			watch(a + 40);
		join
		chk("trigger width", hi, a + 1);
		chk("pulse request", na, 1);
		rd(`PTU_OFF_CTRL, 34'h7C);
		fork
			wr(`PTU_OFF_CTRL, 32'h7D, 2'h0);
			watch(a + 40);
		join
		chk("software width", hi, a + 1);
		rd(`PTU_OFF_CNT, a);
		// Both flags set by earlier matches; write one clears them
		rd(`PTU_OFF_FLAG, 34'h3);
		wr(`PTU_OFF_FLAG, 32'h3, 2'h0);
		rd(`PTU_OFF_FLAG, 34'h0);
		// Capture: every edge select, sources alternating
		wr(`PTU_OFF_CMPP, 32'h0, 2'h0);
		for (k = 0; k < 4; k++)
		begin
			wr(`PTU_OFF_CTRL, 32'hE3 + k * 8 + (k % 2) * 256, 2'h0);
			fork
				m.pulse(k % 2, 5);
				watch(30);
			join
			chk("captures", na, cap_exp[k]);
			chk("capture pin", hi + toen_n, 1);
		end
		// Restart so the counter begins below the new P; no capture edge
		wr(`PTU_OFF_CTRL, 32'hFA, 2'h0);
		wr(`PTU_OFF_CMPP, 32'd20, 2'h0);
		wr(`PTU_OFF_CTRL, 32'hFB, 2'h0);
		watch(110);
		chk("capture wrap", np, 5);
		print_verdict;
	end
endmodule
